/* cfs_top.sv */
// Cube face selection, face coordinates and seamless corner texel synthesis
`timescale 1ns/1ps
module cfs_top #(
  parameter int CW = 16,
  parameter int FW = 16,
  parameter int TW = 12,
  parameter int DW = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Control
  input wire logic seamless_set,
  input wire logic seamless_clr,
  input wire logic depth_as_red_set,
  input wire logic depth_as_red_clr,
  // Direction request
  input wire logic dir_valid,
  input wire logic signed [CW-1:0] coord_s,
  input wire logic signed [CW-1:0] coord_t,
  input wire logic signed [CW-1:0] coord_r,
  input wire logic signed [CW-1:0] coord_q,
  // Texel addressing request
  input wire logic signed [TW-1:0] texel_u,
  input wire logic signed [TW-1:0] texel_v,
  input wire logic [TW-1:0] face_size,
  input wire logic [1:0] wrap_u_mode,
  input wire logic [1:0] wrap_v_mode,
  input wire logic filter_bilinear,
  input wire logic is_depth_tex,
  // Corner samples
  input wire logic [DW-1:0] corner_a,
  input wire logic [DW-1:0] corner_b,
  input wire logic [DW-1:0] corner_c,
  // Face outputs
  output logic face_valid,
  output logic [2:0] face_idx,
  output logic [FW-1:0] face_s,
  output logic [FW-1:0] face_t,
  output logic busy,
  // Addressing outputs
  output logic signed [TW-1:0] addr_u,
  output logic signed [TW-1:0] addr_v,
  output logic fetch_neighbour,
  output logic corner_case,
  output logic [DW-1:0] corner_texel,
  output logic single_red_channel,
  output logic seamless_en
);
  import cfs_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // Control bits
  logic seamless_r, seamless_nxt, depth_red_r, depth_red_nxt;
  always_comb begin
    seamless_nxt = seamless_r;
    if (seamless_set) seamless_nxt = 1'b1;
    else if (seamless_clr) seamless_nxt = 1'b0;
    depth_red_nxt = depth_red_r;
    if (depth_as_red_set) depth_red_nxt = 1'b1;
    else if (depth_as_red_clr) depth_red_nxt = 1'b0;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seamless_r <= SEAMLESS_RST;
      depth_red_r <= DEPTH_RED_RST;
    end else if (clk_en) begin
      seamless_r <= seamless_nxt;
      depth_red_r <= depth_red_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Major axis select; coord_q is never read
  logic signed [CW:0] xs, ys, zs;
  logic [CW:0] ax, ay, az;
  logic [2:0] sel_face;
  logic signed [CW:0] sel_sc, sel_tc;
  logic [CW:0] sel_ma;
  always_comb begin
    // Sign-extend once so that negating the most negative value cannot overflow
    xs = {coord_s[CW-1], coord_s};
    ys = {coord_t[CW-1], coord_t};
    zs = {coord_r[CW-1], coord_r};
    ax = coord_s[CW-1] ? -xs : xs;
    ay = coord_t[CW-1] ? -ys : ys;
    az = coord_r[CW-1] ? -zs : zs;
    // Ties favour x, then y, from the three magnitudes alone
    if (ax >= ay && ax >= az) begin
      sel_face = coord_s[CW-1] ? FACE_NEG_X : FACE_POS_X;
      sel_ma = ax;
    end else if (ay >= az) begin
      sel_face = coord_t[CW-1] ? FACE_NEG_Y : FACE_POS_Y;
      sel_ma = ay;
    end else begin
      sel_face = coord_r[CW-1] ? FACE_NEG_Z : FACE_POS_Z;
      sel_ma = az;
    end
    case (sel_face)
      FACE_POS_X: begin sel_sc = -zs; sel_tc = -ys; end
      FACE_NEG_X: begin sel_sc = zs; sel_tc = -ys; end
      FACE_POS_Y: begin sel_sc = xs; sel_tc = zs; end
      FACE_NEG_Y: begin sel_sc = xs; sel_tc = -zs; end
      FACE_POS_Z: begin sel_sc = xs; sel_tc = -ys; end
      default: begin sel_sc = -xs; sel_tc = -ys; end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // Serial divider: s = (sc + ma) / (2 ma) as unsigned fraction of FW bits
  cfs_state_e st_r, st_nxt;
  logic [CW+1:0] ns_r, ns_nxt, nt_r, nt_nxt, den_r, den_nxt;
  logic [FW-1:0] qs_r, qs_nxt, qt_r, qt_nxt;
  logic [$clog2(FW+1)-1:0] cnt_r, cnt_nxt;
  logic [2:0] face_r, face_nxt;
  logic fv_r, fv_nxt;
  logic busy_r, busy_nxt;
  logic [CW+1:0] rs, rt;
  always_comb begin
    st_nxt = st_r;
    ns_nxt = ns_r;
    nt_nxt = nt_r;
    den_nxt = den_r;
    qs_nxt = qs_r;
    qt_nxt = qt_r;
    cnt_nxt = cnt_r;
    face_nxt = face_r;
    fv_nxt = 1'b0;
    rs = ns_r << 1;
    rt = nt_r << 1;
    case (st_r)
      CFS_IDLE: begin
        if (dir_valid) begin
          // Numerators are sc+ma, tc+ma over denominator 2ma
          ns_nxt = (CW+2)'($signed(sel_sc) + $signed({1'b0, sel_ma}));
          nt_nxt = (CW+2)'($signed(sel_tc) + $signed({1'b0, sel_ma}));
          den_nxt = {sel_ma, 1'b0};
          face_nxt = sel_face;
          qs_nxt = '0;
          qt_nxt = '0;
          cnt_nxt = '0;
          st_nxt = (sel_ma == '0) ? CFS_DONE : CFS_DIV;
        end
      end
      CFS_DIV: begin
        if (rs >= den_r) begin ns_nxt = rs - den_r; qs_nxt = {qs_r[FW-2:0], 1'b1}; end
        else begin ns_nxt = rs; qs_nxt = {qs_r[FW-2:0], 1'b0}; end
        if (rt >= den_r) begin nt_nxt = rt - den_r; qt_nxt = {qt_r[FW-2:0], 1'b1}; end
        else begin nt_nxt = rt; qt_nxt = {qt_r[FW-2:0], 1'b0}; end
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == ($clog2(FW+1))'(FW - 1)) st_nxt = CFS_DONE;
      end
      default: begin
        fv_nxt = 1'b1;
        st_nxt = CFS_IDLE;
      end
    endcase
    // Busy is registered from the next state so the output comes from a flip-flop
    busy_nxt = (st_nxt != CFS_IDLE);
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= CFS_IDLE;
      ns_r <= '0;
      nt_r <= '0;
      den_r <= '0;
      qs_r <= '0;
      qt_r <= '0;
      cnt_r <= '0;
      face_r <= FACE_POS_X;
      fv_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      ns_r <= ns_nxt;
      nt_r <= nt_nxt;
      den_r <= den_nxt;
      qs_r <= qs_nxt;
      qt_r <= qt_nxt;
      cnt_r <= cnt_nxt;
      face_r <= face_nxt;
      fv_r <= fv_nxt;
      busy_r <= busy_nxt;
    end
  end
  assign face_valid = fv_r;
  assign face_idx = face_r;
  assign face_s = qs_r;
  assign face_t = qt_r;
  assign busy = busy_r;
  assign seamless_en = seamless_r;
  //////////////////////////////////////////////////////////////////////////////
  // Texel addressing
  logic signed [TW-1:0] wu, wv;
  logic bu, bv;
  cfs_wrap #(.CW(TW)) u_wrap_u (
    .coord(texel_u), .size(face_size), .wrap_mode(wrap_u_mode),
    .seamless(seamless_r), .filter_bilinear(filter_bilinear),
    .wrapped(wu), .in_border(bu)
  );
  cfs_wrap #(.CW(TW)) u_wrap_v (
    .coord(texel_v), .size(face_size), .wrap_mode(wrap_v_mode),
    .seamless(seamless_r), .filter_bilinear(filter_bilinear),
    .wrapped(wv), .in_border(bv)
  );
  logic signed [TW-1:0] au_r, av_r;
  logic nb_r, nb_nxt, cc_r, cc_nxt, red_r, red_nxt;
  logic [DW-1:0] ct_r, ct_nxt;
  logic [DW+1:0] csum;
  always_comb begin
    csum = {2'b00, corner_a} + {2'b00, corner_b} + {2'b00, corner_c};
    // Exact divide by three keeps equal samples exact
    ct_nxt = DW'(csum / 3);
    nb_nxt = seamless_r && filter_bilinear && (bu ^ bv);
    cc_nxt = seamless_r && filter_bilinear && bu && bv;
    red_nxt = is_depth_tex && depth_red_r;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      au_r <= '0;
      av_r <= '0;
      nb_r <= 1'b0;
      cc_r <= 1'b0;
      ct_r <= '0;
      red_r <= 1'b0;
    end else if (clk_en) begin
      au_r <= wu;
      av_r <= wv;
      nb_r <= nb_nxt;
      cc_r <= cc_nxt;
      ct_r <= ct_nxt;
      red_r <= red_nxt;
    end
  end
  assign addr_u = au_r;
  assign addr_v = av_r;
  assign fetch_neighbour = nb_r;
  assign corner_case = cc_r;
  assign corner_texel = ct_r;
  assign single_red_channel = red_r;
endmodule : cfs_top

/* cfs_pkg.sv */
// Package of constants and types for the cube face select and seamless addressing block
//
// What this block does
// - Use the first three coordinate components as direction; ignore the fourth entirely.
// - Pick the face of the largest-magnitude component, with its sign.
// - Ties resolve deterministically from the three components only: x over y over z.
// - Per face take sc, tc from the fixed sign and swizzle table; ma is major component.
// - s equals half of sc over abs ma plus one; t likewise from tc.
// - One seamless enable bit, set and cleared by control, disabled after reset.
// - Seamless off: ordinary texel selection with configured wrap modes inside the face.
// - Seamless on with nearest filtering: ignore wrap modes, wrap_clamp_edge.
// - Seamless on with bilinear filtering: ignore wrap modes, wrap_clamp_border range.
// - Seamless on with bilinear filtering, border in exactly one of u or v: fetch the texel from the neighbour face.
// - Border in both u and v: build the corner texel as mean of three samples.
// - Corner texel equals the common value when the three samples are equal.
// - Depth and depth-stencil textures are treated as single red channel by default.
package cfs_pkg;
  // Face indices
  localparam logic [2:0] FACE_POS_X = 3'h0;
  localparam logic [2:0] FACE_NEG_X = 3'h1;
  localparam logic [2:0] FACE_POS_Y = 3'h2;
  localparam logic [2:0] FACE_NEG_Y = 3'h3;
  localparam logic [2:0] FACE_POS_Z = 3'h4;
  localparam logic [2:0] FACE_NEG_Z = 3'h5;
  // Wrap mode encodings
  localparam logic [1:0] WRAP_REPEAT = 2'h0;
  localparam logic [1:0] WRAP_CLAMP_EDGE = 2'h1;
  localparam logic [1:0] WRAP_CLAMP_BORDER = 2'h2;
  localparam logic [1:0] WRAP_MIRROR = 2'h3;
  // Reset values
  localparam logic SEAMLESS_RST = 1'b0;
  localparam logic DEPTH_RED_RST = 1'b1;
  // Pipeline states of the divider sequencer
  typedef enum logic [2:0] {
    CFS_IDLE = 3'b001,
    CFS_DIV = 3'b010,
    CFS_DONE = 3'b100
  } cfs_state_e;
endpackage : cfs_pkg

/* cfs_wrap.sv */
// Per-axis texel coordinate wrap with seamless override
`timescale 1ns/1ps
module cfs_wrap #(
  parameter int CW = 12
) (
  // Coordinate in
  input wire logic signed [CW-1:0] coord,
  input wire logic [CW-1:0] size,
  input wire logic [1:0] wrap_mode,
  // Seamless control
  input wire logic seamless,
  input wire logic filter_bilinear,
  // Result
  output logic signed [CW-1:0] wrapped,
  output logic in_border
);
  import cfs_pkg::*;
  logic [1:0] mode;
  logic signed [CW-1:0] sz;
  logic signed [CW-1:0] rem;
  // Seamless overrides configured mode
  always_comb begin
    if (!seamless) begin
      mode = wrap_mode;
    end else if (filter_bilinear) begin
      mode = WRAP_CLAMP_BORDER;
    end else begin
      mode = WRAP_CLAMP_EDGE;
    end
  end
  // Apply the selected wrap function
  always_comb begin
    sz = $signed(size);
    rem = (sz == '0) ? '0 : coord % sz;
    if (rem < 0) begin
      rem = rem + sz;
    end
    wrapped = coord;
    case (mode)
      WRAP_CLAMP_EDGE: begin
        if (coord < 0) wrapped = '0;
        else if (coord > sz - 1) wrapped = sz - CW'(1);
      end
      WRAP_CLAMP_BORDER: begin
        if (coord < -1) wrapped = -CW'(1);
        else if (coord > sz) wrapped = sz;
      end
      WRAP_REPEAT: wrapped = rem;
      default: wrapped = (coord < 0) ? ((-coord - CW'(1)) % sz) : rem;
    endcase
    in_border = (wrapped < 0) || (wrapped >= sz);
  end
endmodule : cfs_wrap

/* cfs_props.sv */
// Port checker of the cube face select block
`timescale 1ns/1ps
module cfs_props #(parameter int TW = 12, parameter int DW = 8) (
  // Control
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic seamless_set,
  input wire logic seamless_en,
  input wire logic dir_valid,
  input wire logic busy,
  input wire logic face_valid,
  // Addressing
  input wire logic [TW-1:0] face_size,
  input wire logic filter_bilinear,
  input wire logic signed [TW-1:0] addr_u,
  input wire logic fetch_neighbour,
  input wire logic [DW-1:0] corner_a,
  input wire logic [DW-1:0] corner_b,
  input wire logic [DW-1:0] corner_c,
  input wire logic [DW-1:0] corner_texel
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // Direction request and its result
  sequence s_take;
    dir_valid && !busy && clk_en;
  endsequence
  sequence s_run;
    busy [*8];
  endsequence
  a_take_busy: assert property (s_take |=> s_run) else $error("busy not held");
  a_face_due: assert property (s_take ##1 busy |-> ##[1:17] face_valid) else $error("face late");
  a_valid_pulse: assert property (face_valid |=> !face_valid) else $error("valid too long");
  a_freeze_hold: assert property (!clk_en |=> $stable(seamless_en) && $stable(busy) && $stable(addr_u) &&
    $stable(corner_texel)) else $error("state moved while frozen");
  ////////////////////////////////////////////////////////////////
  // Seamless addressing
  a_seam_set: assert property (seamless_set && clk_en |-> ##[1:2] seamless_en) else $error("not set");
  a_edge_clamp: assert property (seamless_en && !filter_bilinear && clk_en |=>
    addr_u >= 0 && addr_u < $signed({1'b0, $past(face_size)})) else $error("edge clamp");
  a_border_clamp: assert property (seamless_en && filter_bilinear && clk_en |=>
    addr_u >= -1 && addr_u <= $signed({1'b0, $past(face_size)})) else $error("border clamp");
  a_neigh_gate: assert property (fetch_neighbour |-> $past(seamless_en && filter_bilinear))
    else $error("neighbour fetch");
  a_corner_equal: assert property (clk_en && corner_a == corner_b && corner_b == corner_c |=>
    corner_texel == $past(corner_a)) else $error("corner value");
endmodule : cfs_props
bind cfs_top cfs_props #(.TW(TW), .DW(DW)) cfs_props_inst (.core_clk, .rstn, .clk_en, .seamless_set,
  .seamless_en, .dir_valid, .busy, .face_valid, .face_size, .filter_bilinear, .addr_u, .fetch_neighbour,
  .corner_a, .corner_b, .corner_c, .corner_texel);

/* cfs_fetch_model.sv */
// Texel fetch model that hands three corner samples to the block
`timescale 1ns/1ps
module cfs_fetch_model #(parameter int DW = 8) (
  // Pattern choice
  input wire logic [1:0] pat_sel,
  // Samples
  output logic [DW-1:0] smp_a,
  output logic [DW-1:0] smp_b,
  output logic [DW-1:0] smp_c
);
  // Pattern 0 and 3 unequal, 1 and 2 equal samples
  always_comb begin
    case (pat_sel)
      2'h0: {smp_a, smp_b, smp_c} = {DW'(8'h03), DW'(8'h04), DW'(8'h08)};
      2'h1: {smp_a, smp_b, smp_c} = {3{DW'(8'h09)}};
      2'h2: {smp_a, smp_b, smp_c} = {3*DW{1'b1}};
      default: {smp_a, smp_b, smp_c} = {DW'(8'h10), DW'(8'h20), DW'(8'h30)};
    endcase
  end
endmodule : cfs_fetch_model

/* tb_cube_face_select_seamless.sv */
// Self-checking bench of the cube face select block
`timescale 1ns/1ps
module tb_cube_face_select_seamless;
  import cfs_pkg::*;
  typedef struct {
    logic signed [15:0] x, y, z, q;
    logic [2:0] f;
    logic [15:0] s, t;
  } cfs_row_s;
  logic core_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, dir_valid = 1'b0, filter_bilinear = 1'b0, is_depth_tex = 1'b0;
  logic seamless_set = 1'b0, seamless_clr = 1'b0, depth_as_red_set = 1'b0, depth_as_red_clr = 1'b0;
  logic signed [15:0] coord_s = '0, coord_t = '0, coord_r = '0, coord_q = '0;
  logic signed [11:0] texel_u = '0, texel_v = '0, addr_u, addr_v;
  logic [11:0] face_size = 12'h010;
  logic [1:0] wrap_u_mode = WRAP_CLAMP_EDGE, wrap_v_mode = WRAP_REPEAT, pat_sel = 2'h0;
  logic [7:0] corner_a, corner_b, corner_c, corner_texel;
  logic face_valid, busy, fetch_neighbour, corner_case, single_red_channel, seamless_en;
  logic [2:0] face_idx;
  logic [15:0] face_s, face_t;
  int failures = 0, comparisons = 0;
  cfs_row_s rows [7] = '{
    '{16'sh40, 16'sh10, -16'sh20, 16'sh7, FACE_POS_X, 16'hC000, 16'h6000},
    '{-16'sh40, -16'sh10, 16'sh20, -16'sh7FFF, FACE_NEG_X, 16'hC000, 16'hA000},
    '{16'sh10, 16'sh40, -16'sh20, 16'sh0, FACE_POS_Y, 16'hA000, 16'h4000},
    '{-16'sh20, -16'sh40, 16'sh10, 16'sh1, FACE_NEG_Y, 16'h4000, 16'h6000},
    '{16'sh0, 16'sh30, 16'sh40, 16'sh7FFF, FACE_POS_Z, 16'h8000, 16'h2000},
    '{16'sh20, -16'sh10, -16'sh40, 16'sh3, FACE_NEG_Z, 16'h4000, 16'hA000},
    '{-16'sh40, 16'sh40, -16'sh40, 16'sh5, FACE_NEG_X, 16'h0000, 16'h0000}};
  cfs_top #(.CW(16), .FW(16), .TW(12), .DW(8)) cfs_top_inst (.core_clk, .rstn, .clk_en, .seamless_set,
    .seamless_clr, .depth_as_red_set, .depth_as_red_clr, .dir_valid, .coord_s, .coord_t, .coord_r, .coord_q,
    .texel_u, .texel_v, .face_size, .wrap_u_mode, .wrap_v_mode, .filter_bilinear, .is_depth_tex, .corner_a,
    .corner_b, .corner_c, .face_valid, .face_idx, .face_s, .face_t, .busy, .addr_u, .addr_v, .fetch_neighbour,
    .corner_case, .corner_texel, .single_red_channel, .seamless_en);
  cfs_fetch_model #(.DW(8)) cfs_fetch_model_inst (.pat_sel, .smp_a(corner_a), .smp_b(corner_b), .smp_c(corner_c));
  // Clock
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  // Comparison, verdict and drivers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic ctl(input logic [3:0] p);
    @(posedge core_clk);
    {seamless_set, seamless_clr, depth_as_red_set, depth_as_red_clr} <= p;
    @(posedge core_clk);
    {seamless_set, seamless_clr, depth_as_red_set, depth_as_red_clr} <= 4'h0;
    @(posedge core_clk);
    #1;
  endtask : ctl
  task automatic dir_req(input cfs_row_s r);
    int n = 0;
    @(posedge core_clk);
    dir_valid <= 1'b1;
    {coord_s, coord_t, coord_r, coord_q} <= {r.x, r.y, r.z, r.q};
    @(posedge core_clk);
    dir_valid <= 1'b0;
    #1;
    chk(busy, 1'b1);
    while (face_valid !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(face_valid, 1'b1);
    chk(face_idx, r.f);
    chk(face_s, r.s);
    chk(face_t, r.t);
    chk(busy, 1'b0);
  endtask : dir_req
  task automatic addr_chk(input logic signed [11:0] u, v, input logic [1:0] p, input logic b,
    input logic signed [11:0] eu, ev);
    @(posedge core_clk);
    {texel_u, texel_v, pat_sel, filter_bilinear} <= {u, v, p, b};
    @(posedge core_clk);
    #1;
    chk(addr_u, eu);
    chk(addr_v, ev);
  endtask : addr_chk
  // Watchdog
  initial begin
    #(50 * 3000);
    failures++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(seamless_en, 1'b0);
    foreach (rows[i]) begin
      dir_req(rows[i]);
    end
    addr_chk(-12'sh5, 12'sh12, 2'h0, 1'b1, 12'sh0, 12'sh2);
    chk(fetch_neighbour, 1'b0);
    ctl(4'h8);
    chk(seamless_en, 1'b1);
    addr_chk(-12'sh5, 12'sh14, 2'h0, 1'b0, 12'sh0, 12'shF);
    addr_chk(12'sh3, -12'sh5, 2'h3, 1'b1, 12'sh3, -12'sh1);
    chk(fetch_neighbour, 1'b1);
    chk(corner_case, 1'b0);
    addr_chk(-12'sh5, 12'sh14, 2'h0, 1'b1, -12'sh1, 12'sh10);
    chk(corner_case, 1'b1);
    chk(corner_texel, 8'h05);
    addr_chk(12'sh10, 12'sh10, 2'h1, 1'b1, 12'sh10, 12'sh10);
    chk(corner_texel, 8'h09);
    addr_chk(12'sh3, 12'sh3, 2'h2, 1'b0, 12'sh3, 12'sh3);
    chk(corner_texel, 8'hFF);
    ctl(4'hC);
    chk(seamless_en, 1'b1);
    ctl(4'h4);
    chk(seamless_en, 1'b0);
    @(posedge core_clk);
    is_depth_tex <= 1'b1;
    addr_chk(12'sh3, 12'sh3, 2'h0, 1'b0, 12'sh3, 12'sh3);
    chk(single_red_channel, 1'b1);
    ctl(4'h1);
    addr_chk(12'sh4, 12'sh4, 2'h0, 1'b0, 12'sh4, 12'sh4);
    chk(single_red_channel, 1'b0);
    // Border and mirror modes with seamless off fetch nothing from neighbours
    @(posedge core_clk);
    {wrap_u_mode, wrap_v_mode} <= {WRAP_CLAMP_BORDER, WRAP_MIRROR};
    addr_chk(-12'sh5, -12'sh3, 2'h0, 1'b1, -12'sh1, 12'sh2);
    chk({fetch_neighbour, corner_case}, 2'h0);
    // Clock enable low freezes every register
    @(posedge core_clk);
    clk_en <= 1'b0;
    {texel_u, seamless_set} <= {12'sh7, 1'b1};
    repeat (2) @(posedge core_clk);
    #1;
    chk(addr_u, -12'sh1);
    chk(seamless_en, 1'b0);
    @(posedge core_clk);
    {clk_en, seamless_set} <= 2'b10;
    @(posedge core_clk);
    #1;
    chk(addr_u, 12'sh7);
    chk(seamless_en, 1'b0);
    // Reset in mid-run clears the enable and the divider, depth-as-red returns
    ctl(4'h8);
    @(posedge core_clk);
    {dir_valid, coord_s} <= {1'b1, 16'sh40};
    @(posedge core_clk);
    {dir_valid, rstn} <= 2'b00;
    @(posedge core_clk);
    #1;
    chk({busy, face_valid, seamless_en, single_red_channel}, 4'h0);
    @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(seamless_en, 1'b0);
    chk(single_red_channel, 1'b1);
    dir_req(rows[2]);
    complete_run();
  end
endmodule : tb_cube_face_select_seamless
